// ==== inc/irq_pkg.sv ====
package irq_pkg;

  // Register map
  localparam logic [7:0] ADDR_IE = 8'hA8;
  localparam logic [7:0] ADDR_IE2 = 8'hA9;
  localparam logic [7:0] ADDR_IP = 8'hB8;

  // Reset values
  localparam logic [7:0] IE_RST = 8'h00;
  localparam logic [7:0] IE2_RST = 8'h00;
  localparam logic [7:0] IP_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  // Only the two low bits of the secondary enable exist
  localparam logic [7:0] IE2_WMASK = 8'h03;

  // Enable and priority field positions (shared by both registers)
  localparam int unsigned GLOBAL_EN_BIT = 7;
  localparam int unsigned SB_PRI_BIT = 7;
  localparam int unsigned ADC_BIT = 6;
  localparam int unsigned T2_BIT = 5;
  localparam int unsigned UART_BIT = 4;
  localparam int unsigned T1_BIT = 3;
  localparam int unsigned EXT1_BIT = 2;
  localparam int unsigned T0_BIT = 1;
  localparam int unsigned EXT0_BIT = 0;
  localparam int unsigned PSM_EN_BIT = 1;
  localparam int unsigned SB_EN_BIT = 0;

  // The supply monitor has no priority bit; it sits at this level
  localparam logic PSM_HIGH = 1'b0;

  localparam int unsigned NSRC = 9;
  typedef logic [3:0] src_idx_t;

  // Source index equals its place in the polling order, 0 polled first
  localparam src_idx_t SRC_PSM = 4'h0;
  localparam src_idx_t SRC_EXT0 = 4'h1;
  localparam src_idx_t SRC_ADC = 4'h2;
  localparam src_idx_t SRC_T0 = 4'h3;
  localparam src_idx_t SRC_EXT1 = 4'h4;
  localparam src_idx_t SRC_T1 = 4'h5;
  localparam src_idx_t SRC_SB = 4'h6;
  localparam src_idx_t SRC_UART = 4'h7;
  localparam src_idx_t SRC_T2 = 4'h8;

  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_T0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_T1 = 16'h001B;
  localparam logic [15:0] VEC_UART = 16'h0023;
  localparam logic [15:0] VEC_T2 = 16'h002B;
  localparam logic [15:0] VEC_ADC = 16'h0033;
  localparam logic [15:0] VEC_SB = 16'h003B;
  localparam logic [15:0] VEC_PSM = 16'h0043;
  localparam logic [15:0] VEC_NONE = 16'h0000;

  function automatic logic [15:0] vector_of(input src_idx_t s);
    logic [15:0] v;
    v = VEC_NONE;
    case (s)
      SRC_PSM: v = VEC_PSM;
      SRC_EXT0: v = VEC_EXT0;
      SRC_ADC: v = VEC_ADC;
      SRC_T0: v = VEC_T0;
      SRC_EXT1: v = VEC_EXT1;
      SRC_T1: v = VEC_T1;
      SRC_SB: v = VEC_SB;
      SRC_UART: v = VEC_UART;
      SRC_T2: v = VEC_T2;
      default: v = VEC_NONE;
    endcase
    return v;
  endfunction

  // Lowest set bit wins, matching the polling order
  function automatic src_idx_t first_set(input logic [NSRC-1:0] m);
    src_idx_t r;
    r = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = src_idx_t'(i);
      end
    end
    return r;
  endfunction

endpackage

// ==== inc/irq_sel_if.sv ====
`timescale 1ns/10ps
interface irq_sel_if;
  logic [8:0] cand_hi;
  logic [8:0] cand_lo;
  logic pick_valid;
  irq_pkg::src_idx_t pick_src;
  logic pick_high;
  logic take;
  logic take_high;
  logic ret;
  logic hi_busy;
  logic lo_busy;

  modport arb (
    input cand_hi,
    input cand_lo,
    output pick_valid,
    output pick_src,
    output pick_high
  );

  modport nest (
    input take,
    input take_high,
    input ret,
    output hi_busy,
    output lo_busy
  );

  modport ctl (
    output cand_hi,
    output cand_lo,
    output take,
    output take_high,
    output ret,
    input pick_valid,
    input pick_src,
    input pick_high,
    input hi_busy,
    input lo_busy
  );
endinterface

// ==== src/irq_arbiter.sv ====
`timescale 1ns/10ps
module irq_arbiter (
  irq_sel_if.arb sel
);

  always_comb begin
    sel.pick_valid = 1'b0;
    sel.pick_src = irq_pkg::first_set(sel.cand_lo);
    sel.pick_high = 1'b0;
    if (|sel.cand_hi) begin
      // High level is served before any low request
      sel.pick_valid = 1'b1;
      sel.pick_src = irq_pkg::first_set(sel.cand_hi);
      sel.pick_high = 1'b1;
    end else if (|sel.cand_lo) begin
      sel.pick_valid = 1'b1;
    end
  end

endmodule

// ==== src/irq_nest_tracker.sv ====
`timescale 1ns/10ps
module irq_nest_tracker (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Selection link
  irq_sel_if.nest sel
);

  typedef struct packed {
    logic hi_act;
    logic lo_act;
  } nest_s;

  nest_s st_r;
  nest_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    // A return ends the innermost routine, which is the high one if any
    if (sel.ret) begin
      if (st_r.hi_act) begin
        st_nxt.hi_act = 1'b0;
      end else begin
        st_nxt.lo_act = 1'b0;
      end
    end
    if (sel.take) begin
      if (sel.take_high) begin
        st_nxt.hi_act = 1'b1;
      end else begin
        st_nxt.lo_act = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sel.hi_busy = st_r.hi_act;
  assign sel.lo_busy = st_r.lo_act;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Level is captured at the take; a later re-evaluation may move it
  property p_take_marks_level;
    sel.take && !sel.ret |=>
      ($past(sel.take_high) ? sel.hi_busy : sel.lo_busy)
      ##1 ($past(sel.ret)
           || ($past(sel.take_high, 2) ? sel.hi_busy : sel.lo_busy));
  endproperty
  a_take_marks_level: assert property (p_take_marks_level)
    else $error("accepted level not marked in service");

endmodule

// ==== src/two_level_interrupt_controller.sv ====
`timescale 1ns/10ps
// Overview of operation
// - Global enable bit gates every source
// - Per-source enable bits in enable register
// - Priority register bit one selects high
// - Secondary register enables supply monitor, serial
// - High request preempts running low routine
// - Simultaneous mixed levels: high served first
// - Same level never preempts running routine
// - Fixed polling order within one level
// - Acceptance pushes PC, loads source vector
// - Fixed vector address per source
// - All three registers reset to zero
module two_level_interrupt_controller (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Special function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Source flags
  input wire logic supply_monitor_request_i,
  input wire logic ext0_request_i,
  input wire logic adc_request_i,
  input wire logic timer0_overflow_flag_i,
  input wire logic ext1_request_i,
  input wire logic timer1_overflow_flag_i,
  input wire logic two_wire_request_i,
  input wire logic spi_request_i,
  input wire logic receive_done_flag_i,
  input wire logic transmit_done_flag_i,
  input wire logic timer2_overflow_flag_i,
  input wire logic timer2_external_flag_i,
  // Core handshake
  input wire logic instr_boundary_i,
  input wire logic irq_ack_i,
  input wire logic reti_i,
  output logic irq_req_o,
  output logic [15:0] irq_vector_o,
  output logic irq_high_o
);

  typedef struct packed {
    logic [7:0] ie;
    logic [7:0] ie2;
    logic [7:0] ip;
    logic [7:0] rdata;
    logic req;
    logic high;
    irq_pkg::src_idx_t src;
    logic [15:0] vec;
  } ctl_s;

  ctl_s st_r;
  ctl_s st_nxt;

  irq_sel_if sel ();

  logic [8:0] flags;
  logic [8:0] enables;
  logic [8:0] prio;
  logic [8:0] elig;
  logic global_irq_enable;
  logic take;

  irq_arbiter u_arb (
    .sel(sel.arb)
  );

  irq_nest_tracker u_nest (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .sel(sel.nest)
  );

  // Bit order follows the polling order, index 0 polled first
  always_comb begin
    flags = '0;
    flags[irq_pkg::SRC_PSM] = supply_monitor_request_i;
    flags[irq_pkg::SRC_EXT0] = ext0_request_i;
    flags[irq_pkg::SRC_ADC] = adc_request_i;
    flags[irq_pkg::SRC_T0] = timer0_overflow_flag_i;
    flags[irq_pkg::SRC_EXT1] = ext1_request_i;
    flags[irq_pkg::SRC_T1] = timer1_overflow_flag_i;
    flags[irq_pkg::SRC_SB] = two_wire_request_i | spi_request_i;
    flags[irq_pkg::SRC_UART] = receive_done_flag_i | transmit_done_flag_i;
    flags[irq_pkg::SRC_T2] = timer2_overflow_flag_i
                           | timer2_external_flag_i;
  end

  always_comb begin
    enables = '0;
    enables[irq_pkg::SRC_PSM] = st_r.ie2[irq_pkg::PSM_EN_BIT];
    enables[irq_pkg::SRC_SB] = st_r.ie2[irq_pkg::SB_EN_BIT];
    enables[irq_pkg::SRC_EXT0] = st_r.ie[irq_pkg::EXT0_BIT];
    enables[irq_pkg::SRC_ADC] = st_r.ie[irq_pkg::ADC_BIT];
    enables[irq_pkg::SRC_T0] = st_r.ie[irq_pkg::T0_BIT];
    enables[irq_pkg::SRC_EXT1] = st_r.ie[irq_pkg::EXT1_BIT];
    enables[irq_pkg::SRC_T1] = st_r.ie[irq_pkg::T1_BIT];
    enables[irq_pkg::SRC_UART] = st_r.ie[irq_pkg::UART_BIT];
    enables[irq_pkg::SRC_T2] = st_r.ie[irq_pkg::T2_BIT];
  end

  always_comb begin
    prio = '0;
    prio[irq_pkg::SRC_PSM] = irq_pkg::PSM_HIGH;
    prio[irq_pkg::SRC_SB] = st_r.ip[irq_pkg::SB_PRI_BIT];
    prio[irq_pkg::SRC_EXT0] = st_r.ip[irq_pkg::EXT0_BIT];
    prio[irq_pkg::SRC_ADC] = st_r.ip[irq_pkg::ADC_BIT];
    prio[irq_pkg::SRC_T0] = st_r.ip[irq_pkg::T0_BIT];
    prio[irq_pkg::SRC_EXT1] = st_r.ip[irq_pkg::EXT1_BIT];
    prio[irq_pkg::SRC_T1] = st_r.ip[irq_pkg::T1_BIT];
    prio[irq_pkg::SRC_UART] = st_r.ip[irq_pkg::UART_BIT];
    prio[irq_pkg::SRC_T2] = st_r.ip[irq_pkg::T2_BIT];
  end

  assign global_irq_enable = st_r.ie[irq_pkg::GLOBAL_EN_BIT];
  assign elig = flags & enables & {9{global_irq_enable}};

  // A running high routine blocks all; a running low one blocks low
  assign sel.cand_hi = sel.hi_busy ? '0 : (elig & prio);
  assign sel.cand_lo = (sel.hi_busy || sel.lo_busy) ? '0 : (elig & ~prio);

  assign take = irq_ack_i && st_r.req;
  assign sel.take = take;
  assign sel.take_high = st_r.high;
  assign sel.ret = reti_i;

  always_comb begin
    st_nxt = st_r;
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        irq_pkg::ADDR_IE: st_nxt.ie = sfr_wdata_i;
        irq_pkg::ADDR_IP: st_nxt.ip = sfr_wdata_i;
        // Reserved bits never store anything
        irq_pkg::ADDR_IE2: st_nxt.ie2 = sfr_wdata_i & irq_pkg::IE2_WMASK;
        default: ;
      endcase
    end
    case (sfr_addr_i)
      irq_pkg::ADDR_IE: st_nxt.rdata = st_r.ie;
      irq_pkg::ADDR_IP: st_nxt.rdata = st_r.ip;
      irq_pkg::ADDR_IE2: st_nxt.rdata = st_r.ie2 & irq_pkg::IE2_WMASK;
      default: st_nxt.rdata = irq_pkg::UNMAPPED_RDATA;
    endcase
    // Acceptance retires the request; the core pushed the PC as it raised the acknowledge
    if (take) begin
      st_nxt.req = 1'b0;
    end else if (instr_boundary_i) begin
      // Requests are only reconsidered between instructions
      st_nxt.req = sel.pick_valid;
      st_nxt.high = sel.pick_high;
      st_nxt.src = sel.pick_src;
      st_nxt.vec = irq_pkg::vector_of(sel.pick_src);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r.ie <= irq_pkg::IE_RST;
      st_r.ie2 <= irq_pkg::IE2_RST;
      st_r.ip <= irq_pkg::IP_RST;
      st_r.rdata <= irq_pkg::UNMAPPED_RDATA;
      st_r.req <= 1'b0;
      st_r.high <= 1'b0;
      st_r.src <= irq_pkg::SRC_PSM;
      st_r.vec <= irq_pkg::VEC_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata_o = st_r.rdata;
  assign irq_req_o = st_r.req;
  assign irq_vector_o = st_r.vec;
  assign irq_high_o = st_r.high;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_eval;
    instr_boundary_i && !take;
  endsequence

  sequence s_write_ie2;
    sfr_wr_i && sfr_addr_i == irq_pkg::ADDR_IE2;
  endsequence

  sequence s_read_ie2_back;
    ##1 (sfr_addr_i == irq_pkg::ADDR_IE2) ##1 1'b1;
  endsequence

  property p_global_gate;
    s_eval and !global_irq_enable |=> !irq_req_o;
  endproperty
  a_global_gate: assert property (p_global_gate)
    else $error("request raised with global enable off");

  property p_single_enable;
    s_eval and !sel.hi_busy && !sel.lo_busy && global_irq_enable
      && flags == 9'h002 && st_r.ie[irq_pkg::EXT0_BIT]
      |=> irq_req_o && irq_vector_o == irq_pkg::VEC_EXT0;
  endproperty
  a_single_enable: assert property (p_single_enable)
    else $error("enabled external 0 not requested");

  property p_level_select;
    s_eval and (|sel.cand_hi) |=> irq_req_o && irq_high_o;
  endproperty
  a_level_select: assert property (p_level_select)
    else $error("high candidate not presented at high level");

  property p_ie2_reads_back;
    s_write_ie2 ##0 s_read_ie2_back |->
      sfr_rdata_o == ($past(sfr_wdata_i, 2) & irq_pkg::IE2_WMASK);
  endproperty
  a_ie2_reads_back: assert property (p_ie2_reads_back)
    else $error("secondary enable read differs from write");

  property p_preempt_low;
    s_eval and sel.lo_busy && !sel.hi_busy && (|(elig & prio))
      |=> irq_req_o && irq_high_o;
  endproperty
  a_preempt_low: assert property (p_preempt_low)
    else $error("high request did not preempt low routine");

  property p_high_first;
    s_eval and (|(elig & prio)) && (|(elig & ~prio)) && !sel.hi_busy
      |=> irq_high_o;
  endproperty
  a_high_first: assert property (p_high_first)
    else $error("low request chosen over high one");

  property p_no_same_level;
    s_eval and (sel.hi_busy || (sel.lo_busy && !(|(elig & prio))))
      |=> !irq_req_o;
  endproperty
  a_no_same_level: assert property (p_no_same_level)
    else $error("same level request preempted a routine");

  property p_poll_order;
    s_eval and sel.pick_valid |=>
      irq_vector_o == irq_pkg::vector_of(irq_pkg::first_set(
        $past(sel.pick_high ? sel.cand_hi : sel.cand_lo)));
  endproperty
  a_poll_order: assert property (p_poll_order)
    else $error("polling order violated");

  // The next boundary may already present a new level, so use the old one
  property p_ack_retires;
    take |=> !irq_req_o ##1 ($past(sel.ret)
      || ($past(st_r.high, 2) ? sel.hi_busy : sel.lo_busy));
  endproperty
  a_ack_retires: assert property (p_ack_retires)
    else $error("accepted request not retired");

  property p_vector_map;
    irq_req_o |-> irq_vector_o == irq_pkg::vector_of(st_r.src)
      && irq_vector_o != irq_pkg::VEC_NONE;
  endproperty
  a_vector_map: assert property (p_vector_map)
    else $error("vector does not match source");

  property p_reset_zero;
    !$past(rst_b_i) |-> st_r.ie == 8'h00 && st_r.ip == 8'h00
      && st_r.ie2 == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("registers not cleared by reset");

  property p_request_cause;
    $rose(irq_req_o) |-> $past(instr_boundary_i) && $past(|elig);
  endproperty
  a_request_cause: assert property (p_request_cause)
    else $error("request without enabled flag at boundary");

  property p_reserved_zero;
    $past(sfr_addr_i) == irq_pkg::ADDR_IE2 |-> sfr_rdata_o[7:2] == 6'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved secondary bits read nonzero");

endmodule

// ==== test/core_model.sv ====
`timescale 1ns/10ps
module core_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Request from the controller
  input wire logic irq_req_i,
  input wire logic [15:0] irq_vector_i,
  input wire logic irq_high_i,
  // Bench control
  input wire logic [3:0] ack_delay_i,
  input wire logic reti_cmd_i,
  // Handshake to the controller
  output logic instr_boundary_o,
  output logic irq_ack_o,
  output logic reti_o,
  // Observation
  output logic taken_o,
  output logic taken_high_o,
  output logic [15:0] taken_vec_o
);
  logic [15:0] pc = 16'h0100;
  logic [15:0] stack[$];
  logic [3:0] wait_cnt = 4'h0;

  initial begin
    {instr_boundary_o, irq_ack_o, reti_o, taken_o, taken_high_o} = 5'h00;
    taken_vec_o = 16'h0000;
  end

  // Acts on the falling edge so the controller sees stable inputs
  always @(negedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      instr_boundary_o <= 1'b0;
      irq_ack_o <= 1'b0;
      reti_o <= 1'b0;
      taken_o <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      instr_boundary_o <= 1'b1;
      irq_ack_o <= 1'b0;
      reti_o <= 1'b0;
      taken_o <= 1'b0;
      if (reti_cmd_i && !reti_o && stack.size() > 0) begin
        reti_o <= 1'b1;
        pc <= stack.pop_back();
      end
      // A slow core lets the request wait before taking it
      if (irq_req_i && !irq_ack_o) begin
        if (wait_cnt >= ack_delay_i) begin
          irq_ack_o <= 1'b1;
          stack.push_back(pc + 16'h0001);
          pc <= irq_vector_i;
          taken_o <= 1'b1;
          taken_high_o <= irq_high_i;
          taken_vec_o <= irq_vector_i;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end else begin
        wait_cnt <= 4'h0;
      end
    end
  end
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [11:0] flags = 12'h000;
  logic [3:0] ack_delay = 4'h0;
  logic reti_cmd = 1'b0;
  logic rd_chk = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic bnd, ack, reti, irq_req_o, irq_high_o, taken, taken_high;
  logic [15:0] irq_vector_o, taken_vec;
  logic [16:0] exp_q[$];
  int err_total = 0;
  int total_checks = 0;
  logic [15:0] vtab [9] = '{irq_pkg::VEC_PSM, irq_pkg::VEC_EXT0,
    irq_pkg::VEC_ADC, irq_pkg::VEC_T0, irq_pkg::VEC_EXT1, irq_pkg::VEC_T1,
    irq_pkg::VEC_SB, irq_pkg::VEC_UART, irq_pkg::VEC_T2};
  int ipbit [9] = '{0, 0, 6, 1, 2, 3, 7, 4, 5};

  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end

  two_level_interrupt_controller u_dut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .supply_monitor_request_i(flags[0]), .ext0_request_i(flags[1]),
    .adc_request_i(flags[2]), .timer0_overflow_flag_i(flags[3]),
    .ext1_request_i(flags[4]), .timer1_overflow_flag_i(flags[5]),
    .two_wire_request_i(flags[6]), .spi_request_i(flags[7]),
    .receive_done_flag_i(flags[8]), .transmit_done_flag_i(flags[9]),
    .timer2_overflow_flag_i(flags[10]), .timer2_external_flag_i(flags[11]),
    .instr_boundary_i(bnd), .irq_ack_i(ack), .reti_i(reti),
    .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
    .irq_high_o(irq_high_o)
  );

  core_model u_core (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .irq_req_i(irq_req_o),
    .irq_vector_i(irq_vector_o), .irq_high_i(irq_high_o),
    .ack_delay_i(ack_delay), .reti_cmd_i(reti_cmd),
    .instr_boundary_o(bnd), .irq_ack_o(ack), .reti_o(reti),
    .taken_o(taken), .taken_high_o(taken_high), .taken_vec_o(taken_vec)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic pop_check(input logic [16:0] got);
    logic [16:0] e;
    if (exp_q.size() == 0) begin
      err_total++;
      $display("mismatch t=%0t unexpected result %h", $time, got);
    end else begin
      e = exp_q.pop_front();
      `CHK(got, e)
    end
  endtask

  // Oldest note is matched against each vector taken or register read
  always @(posedge core_clk_i) begin
    if (taken) begin
      pop_check({taken_high, taken_vec});
    end
    if (rd_chk) begin
      #1;
      pop_check({9'h000, sfr_rdata_o});
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(negedge core_clk_i);
    sfr_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({9'h000, e});
    @(negedge core_clk_i);
    sfr_addr_i <= a;
    rd_chk <= 1'b1;
    @(negedge core_clk_i);
    rd_chk <= 1'b0;
  endtask

  task automatic take(input int s, input logic hi);
    exp_q.push_back({hi, vtab[s]});
    ack_delay <= 4'($urandom_range(3));
    for (int i = 0; i < 60 && exp_q.size() > 0; i++) begin
      @(negedge core_clk_i);
    end
    if (exp_q.size() != 0) begin
      err_total++;
      $display("mismatch t=%0t no vector taken", $time);
      complete_run();
    end
  endtask

  task automatic retire();
    @(negedge core_clk_i);
    reti_cmd <= 1'b1;
    @(negedge core_clk_i);
    reti_cmd <= 1'b0;
  endtask

  task automatic quiet();
    repeat (10) @(negedge core_clk_i);
    `CHK(irq_req_o, 1'b0)
  endtask

  // Paired sources set one member at random, or clear both
  function automatic logic [11:0] fmask(input int s, input bit both);
    logic [11:0] m;
    if (s < 6) m = 12'h001 << s;
    else if (both) m = 12'h003 << (2 * s - 6);
    else m = 12'h001 << (2 * s - 6 + $urandom_range(1));
    return m;
  endfunction

  task automatic setf(input int s);
    @(negedge core_clk_i);
    flags <= flags | fmask(s, 1'b0);
  endtask

  task automatic clrf(input int s);
    @(negedge core_clk_i);
    flags <= flags & ~fmask(s, 1'b1);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    $display("mismatch t=%0t run limit reached", $time);
    complete_run();
  end

  initial begin
    logic [7:0] d;
    logic [11:0] m;
    void'($urandom(75));
    repeat (12) @(negedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(irq_pkg::ADDR_IE, 8'h00);
    rd(irq_pkg::ADDR_IE2, 8'h00);
    rd(irq_pkg::ADDR_IP, 8'h00);
    rd(8'hA0, 8'h00);
    $display("test reset done");
    d = 8'($urandom);
    wr(irq_pkg::ADDR_IE, d);
    rd(irq_pkg::ADDR_IE, d);
    wr(irq_pkg::ADDR_IP, ~d);
    rd(irq_pkg::ADDR_IP, ~d);
    wr(irq_pkg::ADDR_IE2, 8'hFF);
    rd(irq_pkg::ADDR_IE2, 8'h03);
    wr(irq_pkg::ADDR_IE2, 8'hFE);
    rd(irq_pkg::ADDR_IE2, 8'h02);
    wr(8'hA0, 8'h5A);
    rd(8'hA0, 8'h00);
    rd(irq_pkg::ADDR_IE, d);
    $display("test registers done");
    wr(irq_pkg::ADDR_IE2, 8'h03);
    wr(irq_pkg::ADDR_IE, 8'h7F);
    flags <= 12'hFFF;
    quiet();
    wr(irq_pkg::ADDR_IE2, 8'h00);
    wr(irq_pkg::ADDR_IE, 8'h80);
    quiet();
    flags <= 12'h000;
    $display("test gating done");
    wr(irq_pkg::ADDR_IP, 8'h00);
    wr(irq_pkg::ADDR_IE2, 8'h03);
    wr(irq_pkg::ADDR_IE, 8'hFF);
    m = 12'h000;
    for (int s = 0; s < 9; s++) m = m | fmask(s, 1'b0);
    @(negedge core_clk_i);
    flags <= m;
    for (int s = 0; s < 9; s++) begin
      take(s, 1'b0);
      clrf(s);
      retire();
    end
    $display("test polling done");
    for (int s = 1; s < 9; s++) begin
      wr(irq_pkg::ADDR_IP, 8'h01 << ipbit[s]);
      @(negedge core_clk_i);
      flags <= fmask(s, 1'b0) | 12'h001;
      take(s, 1'b1);
      clrf(s);
      retire();
      take(0, 1'b0);
      clrf(0);
      retire();
    end
    $display("test levels done");
    wr(irq_pkg::ADDR_IP, 8'h20);
    setf(1);
    take(1, 1'b0);
    clrf(1);
    setf(7);
    quiet();
    setf(8);
    take(8, 1'b1);
    clrf(8);
    retire();
    quiet();
    retire();
    take(7, 1'b0);
    clrf(7);
    retire();
    $display("test nesting done");
    complete_run();
  end
endmodule
